// ==== eep_pkg.sv ====
// constants, types and helpers of the serial eeprom front end
package eep_pkg;

    // ****************************************************************
    // geometry and opcodes
    // ****************************************************************
    localparam int ADDR_W = 13;
    localparam int PAGE_W = 5;
    localparam int MEM_WORDS = 8192;
    localparam logic [5:0] PAGE_FULL = 6'h20;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;

    // ****************************************************************
    // status byte layout and protection
    // ****************************************************************
    localparam int ST_PIN_EN = 7;
    localparam int ST_BP_HI = 3;
    localparam int ST_BP_LO = 2;
    localparam int ST_LATCH = 1;
    localparam int ST_BUSY = 0;
    localparam logic [7:0] ST_NV_RESET = 8'h00;
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [12:0] QUARTER_BASE = 13'h1800;
    localparam logic [12:0] HALF_BASE = 13'h1000;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CORE_CLK_NS = 25;
    localparam int WRITE_CYCLE_NS = 5000000;
    localparam int WRITE_CYCLE_CLKS = WRITE_CYCLE_NS / CORE_CLK_NS;
    localparam int BUSY_CNT_W = 18;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        PH_OPC = 3'h0,
        PH_ADH = 3'h1,
        PH_ADL = 3'h3,
        PH_DAT = 3'h2,
        PH_IGN = 3'h6
    } eep_phase_e;

    typedef enum logic [2:0] {
        K_NONE = 3'h0,
        K_SET = 3'h1,
        K_CLR = 3'h3,
        K_SR = 3'h2,
        K_WR = 3'h6
    } eep_commit_e;

    typedef enum logic {
        CS_IDLE = 1'h0,
        CS_PROG = 1'h1
    } eep_core_state_e;

    typedef struct packed {
        eep_phase_e phase;
        logic [2:0] bit_cnt;
        logic [6:0] shreg;
        logic [7:0] opcode;
        logic [12:0] addr;
        logic mute;
        logic [7:0] st_s1;
        logic [7:0] st_s2;
    } eep_link_s;

    typedef struct packed {
        eep_commit_e kind;
        logic [7:0] sr_data;
        logic [12:0] wr_addr;
        logic [5:0] wr_cnt;
    } eep_result_s;

    typedef struct packed {
        logic so;
        logic so_en;
    } eep_out_s;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic wp_s1;
        logic wp_s2;
        logic armed;
        eep_core_state_e state;
        logic latch;
        logic pin_en;
        logic [1:0] bp;
        logic [17:0] busy_cnt;
        eep_commit_e prog_kind;
        logic [5:0] prog_idx;
        logic [5:0] prog_cnt;
        logic [12:0] prog_addr;
        logic [7:0] sr_data;
    } eep_core_s;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic is_protected(input logic [1:0] bp, input logic [12:0] a);
        logic hit;
        hit = 1'b1;
        case (bp)
            BP_NONE: hit = 1'b0;
            BP_QUARTER: hit = (a >= QUARTER_BASE);
            BP_HALF: hit = (a >= HALF_BASE);
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

    function automatic logic [12:0] page_step(input logic [12:0] a, input logic [4:0] off);
        logic [4:0] lo;
        lo = 5'(a[4:0] + off);
        return {a[12:5], lo};
    endfunction

endpackage

// ==== eep_spi_eeprom.sv ====
// serial eeprom front end: link shifter, command commit, programming timer, array
`timescale 1ns/1ps
module eep_spi_eeprom #(
    parameter int PROG_CYCLES = eep_pkg::WRITE_CYCLE_CLKS
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial link from the host
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    output logic so,
    output logic so_oe,
    // write protect pin
    input wire logic wp_n
);

    // ****************************************************************
    // state
    // ****************************************************************
    eep_pkg::eep_link_s lk;
    eep_pkg::eep_link_s next_lk;
    eep_pkg::eep_result_s res;
    eep_pkg::eep_result_s next_res;
    eep_pkg::eep_out_s ot;
    eep_pkg::eep_out_s next_ot;
    eep_pkg::eep_core_s cr;
    eep_pkg::eep_core_s next_cr;

    localparam logic [17:0] BUSY_LAST = 18'(PROG_CYCLES - 1);

    logic [7:0] mem [0:eep_pkg::MEM_WORDS-1];
    logic [7:0] pbuf [0:(1 << eep_pkg::PAGE_W)-1];

    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    logic [7:0] tx_byte;
    logic [7:0] status_byte;
    logic link_busy;
    logic byte_done;
    logic pbuf_we;
    logic drive;
    logic cs_rise;
    logic mem_we;
    logic [12:0] mem_waddr;
    logic [7:0] mem_wdata;

    // ****************************************************************
    // status byte, built from core flops
    // ****************************************************************
    always_comb begin
        status_byte = 8'h00;
        status_byte[eep_pkg::ST_PIN_EN] = cr.pin_en;
        status_byte[eep_pkg::ST_BP_HI] = cr.bp[1];
        status_byte[eep_pkg::ST_BP_LO] = cr.bp[0];
        status_byte[eep_pkg::ST_LATCH] = cr.latch;
        status_byte[eep_pkg::ST_BUSY] = (cr.state == eep_pkg::CS_PROG);
    end

    // ****************************************************************
    // link side, rising sck
    // ****************************************************************
    // msb first: the new bit enters at the bottom
    assign byte_in = {lk.shreg, si};
    assign link_busy = lk.st_s2[eep_pkg::ST_BUSY];
    assign byte_done = hold_n && (lk.bit_cnt == 3'h7);
    assign rd_byte = mem[lk.addr];

    always_comb begin
        next_lk = lk;
        next_res = res;
        // status crosses as a quasi-static word through two flops
        next_lk.st_s1 = status_byte;
        next_lk.st_s2 = lk.st_s1;
        // hold low at a rising edge means paused: edge ignored, state kept except the status sync flops st_s1/st_s2
        if (hold_n) begin
            next_lk.shreg = byte_in[6:0];
            next_lk.bit_cnt = lk.bit_cnt + 3'h1;
            if (lk.bit_cnt == 3'h0) begin
                // a new bit after a full byte abandons any pending commit
                next_res.kind = eep_pkg::K_NONE;
            end
            if (lk.bit_cnt == 3'h7) begin
                case (lk.phase)
                    eep_pkg::PH_OPC: begin
                        next_lk.opcode = byte_in;
                        next_lk.phase = eep_pkg::PH_IGN;
                        next_res.wr_cnt = 6'h00;
                        case (byte_in)
                            eep_pkg::OP_READ: begin
                                next_lk.phase = eep_pkg::PH_ADH;
                                next_lk.mute = link_busy;
                            end
                            eep_pkg::OP_WRITE: next_lk.phase = eep_pkg::PH_ADH;
                            eep_pkg::OP_STAT_RD: next_lk.phase = eep_pkg::PH_DAT;
                            eep_pkg::OP_STAT_WR: next_lk.phase = eep_pkg::PH_DAT;
                            eep_pkg::OP_LATCH_SET: next_res.kind = eep_pkg::K_SET;
                            eep_pkg::OP_LATCH_CLR: next_res.kind = eep_pkg::K_CLR;
                            default: next_lk.phase = eep_pkg::PH_IGN;
                        endcase
                    end
                    eep_pkg::PH_ADH: begin
                        // top three address bits are don't-care
                        next_lk.addr[12:8] = byte_in[4:0];
                        next_lk.phase = eep_pkg::PH_ADL;
                    end
                    eep_pkg::PH_ADL: begin
                        next_lk.addr[7:0] = byte_in;
                        next_lk.phase = eep_pkg::PH_DAT;
                        next_res.wr_addr = {lk.addr[12:8], byte_in};
                        next_res.wr_cnt = 6'h00;
                    end
                    eep_pkg::PH_DAT: begin
                        case (lk.opcode)
                            eep_pkg::OP_READ: begin
                                // 13-bit counter wraps top to zero by itself
                                next_lk.addr = lk.addr + 13'h1;
                            end
                            eep_pkg::OP_WRITE: begin
                                if (!link_busy) begin
                                    next_lk.addr = eep_pkg::page_step(lk.addr, 5'h1);
                                    next_res.kind = eep_pkg::K_WR;
                                    if (res.wr_cnt != eep_pkg::PAGE_FULL) begin
                                        next_res.wr_cnt = res.wr_cnt + 6'h1;
                                    end
                                end
                            end
                            eep_pkg::OP_STAT_WR: begin
                                // only the first data byte counts
                                if (res.wr_cnt == 6'h00) begin
                                    next_res.kind = eep_pkg::K_SR;
                                    next_res.sr_data = byte_in;
                                    next_res.wr_cnt = 6'h01;
                                end
                            end
                            default: next_lk.phase = eep_pkg::PH_DAT;
                        endcase
                    end
                    default: next_lk.phase = eep_pkg::PH_IGN;
                endcase
            end
        end
    end

    assign pbuf_we = byte_done && (lk.phase == eep_pkg::PH_DAT) &&
                     (lk.opcode == eep_pkg::OP_WRITE) && !link_busy;

    // deselect clears the sequence, so the next edge is bit one
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // commit info must survive deselect, so it is not cleared by it
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            res <= '0;
        end else begin
            res <= next_res;
        end
    end

    // page buffer, read by the core only while programming
    always_ff @(posedge sck) begin
        if (pbuf_we) begin
            pbuf[lk.addr[4:0]] <= byte_in;
        end
    end

    // ****************************************************************
    // link side, falling sck: serial output
    // ****************************************************************
    assign tx_byte = (lk.opcode == eep_pkg::OP_STAT_RD) ? lk.st_s2 : rd_byte;
    assign drive = (lk.phase == eep_pkg::PH_DAT) &&
                   ((lk.opcode == eep_pkg::OP_STAT_RD) ||
                    ((lk.opcode == eep_pkg::OP_READ) && !lk.mute));

    always_comb begin
        next_ot = ot;
        // hold seen low across a high phase pauses from this fall on
        if (hold_n) begin
            next_ot.so = tx_byte[3'h7 - lk.bit_cnt];
            next_ot.so_en = drive;
        end
    end

    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            ot <= '0;
        end else begin
            ot <= next_ot;
        end
    end

    assign so = ot.so;
    // pause must float the pin at once, without waiting for any clock
    assign so_oe = ot.so_en && hold_n && !cs_n;

    // ****************************************************************
    // core side: commit on deselect and programming
    // ****************************************************************
    // res is static here: sck is idle once select has risen
    assign cs_rise = cr.cs_s2 && !cr.cs_d;

    always_comb begin
        next_cr = cr;
        mem_we = 1'b0;
        mem_waddr = cr.prog_addr;
        mem_wdata = 8'h00;
        next_cr.cs_s1 = cs_n;
        next_cr.cs_s2 = cr.cs_s1;
        next_cr.cs_d = cr.cs_s2;
        next_cr.wp_s1 = wp_n;
        next_cr.wp_s2 = cr.wp_s1;
        if (cr.cs_d && !cr.cs_s2) begin
            next_cr.armed = 1'b1;
        end
        case (cr.state)
            eep_pkg::CS_IDLE: begin
                if (cs_rise && cr.armed) begin
                    case (res.kind)
                        eep_pkg::K_SET: next_cr.latch = 1'b1;
                        eep_pkg::K_CLR: next_cr.latch = 1'b0;
                        eep_pkg::K_SR: begin
                            // pin only matters while its enable bit is set
                            if (cr.latch && !(cr.pin_en && !cr.wp_s2)) begin
                                next_cr.state = eep_pkg::CS_PROG;
                                next_cr.prog_kind = eep_pkg::K_SR;
                                next_cr.sr_data = res.sr_data;
                                next_cr.busy_cnt = '0;
                            end
                        end
                        eep_pkg::K_WR: begin
                            // whole burst lies in one page, so the start decides
                            if (cr.latch && !eep_pkg::is_protected(cr.bp, res.wr_addr)) begin
                                next_cr.state = eep_pkg::CS_PROG;
                                next_cr.prog_kind = eep_pkg::K_WR;
                                next_cr.prog_addr = res.wr_addr;
                                next_cr.prog_cnt = res.wr_cnt;
                                next_cr.prog_idx = 6'h00;
                                next_cr.busy_cnt = '0;
                            end
                        end
                        default: next_cr.state = eep_pkg::CS_IDLE;
                    endcase
                end
            end
            eep_pkg::CS_PROG: begin
                // nothing from select or the protect pin reaches a running cycle
                next_cr.busy_cnt = cr.busy_cnt + 18'h1;
                if ((cr.prog_kind == eep_pkg::K_WR) && (cr.prog_idx != cr.prog_cnt)) begin
                    mem_we = 1'b1;
                    mem_waddr = eep_pkg::page_step(cr.prog_addr, cr.prog_idx[4:0]);
                    mem_wdata = pbuf[mem_waddr[4:0]];
                    next_cr.prog_idx = cr.prog_idx + 6'h1;
                end
                if (cr.busy_cnt == BUSY_LAST) begin
                    next_cr.state = eep_pkg::CS_IDLE;
                    next_cr.latch = 1'b0;
                    if (cr.prog_kind == eep_pkg::K_SR) begin
                        next_cr.pin_en = cr.sr_data[eep_pkg::ST_PIN_EN];
                        next_cr.bp = {cr.sr_data[eep_pkg::ST_BP_HI],
                                      cr.sr_data[eep_pkg::ST_BP_LO]};
                    end
                end
            end
            default: next_cr.state = eep_pkg::CS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cr <= '0;
            cr.cs_s1 <= 1'b1;
            cr.cs_s2 <= 1'b1;
            cr.cs_d <= 1'b1;
            cr.wp_s1 <= 1'b1;
            cr.wp_s2 <= 1'b1;
            cr.latch <= 1'b0;
            cr.pin_en <= eep_pkg::ST_NV_RESET[eep_pkg::ST_PIN_EN];
            cr.bp <= {eep_pkg::ST_NV_RESET[eep_pkg::ST_BP_HI],
                      eep_pkg::ST_NV_RESET[eep_pkg::ST_BP_LO]};
        end else begin
            cr <= next_cr;
        end
    end

    // array written only by the core; read asynchronously from the link
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

endmodule

// ==== eep_port_checker.sv ====
// port assertions for the serial eeprom front end
`timescale 1ns/1ps
module eep_port_checker (
    // clocks and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic so,
    input wire logic so_oe,
    // protect pin
    input wire logic wp_n
);
    logic [5:0] rises;
    logic so_r;
    logic oe_r;
    logic hold_r;
    // live rises in a frame; select high clears it, as it clears the shifter
    // enable from the last frame must not look like driving in the next one
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            rises <= 6'h00;
            oe_r <= 1'b0;
        end else begin
            oe_r <= so_oe;
            if (hold_n && rises != 6'h3f) begin
                rises <= rises + 6'h01;
            end
        end
    end
    always_ff @(posedge sck) begin
        so_r <= so;
        hold_r <= hold_n;
    end
    sequence s_live;
        hold_n && hold_r;
    endsequence
    sequence s_paused3;
        !hold_n [*3];
    endsequence
    AST_HOLD_FLOATS: assert property (@(posedge core_clk) disable iff (rst)
        !hold_n |-> !so_oe) else $error("output driven while paused");
    AST_DESELECT_FLOATS: assert property (@(posedge core_clk) disable iff (rst)
        cs_n |-> !so_oe) else $error("output driven while deselected");
    AST_RESET_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        $fell(rst) |-> !so_oe [*4]) else $error("output driven after reset");
    AST_SO_AFTER_FALL: assert property (@(negedge sck) disable iff (rst || cs_n)
        s_live |-> so == so_r) else $error("output data moved while clock high");
    AST_OE_AFTER_FALL: assert property (@(negedge sck) disable iff (rst || cs_n)
        s_live |-> so_oe == oe_r) else $error("output enable moved while clock high");
    AST_NO_EARLY_DRIVE: assert property (@(posedge sck) disable iff (rst || cs_n)
        so_oe |-> rises >= 6'h08) else $error("output driven before opcode complete");
    AST_KEEP_DRIVING: assert property (@(posedge sck) disable iff (rst || cs_n)
        hold_n && hold_r && oe_r |-> so_oe) else $error("output stopped mid read");
    AST_PAUSE_FREEZES: assert property (@(negedge sck) disable iff (rst || cs_n)
        s_paused3 |-> $stable(so)) else $error("output moved while paused");
endmodule
bind eep_spi_eeprom eep_port_checker u_chk (.core_clk(core_clk), .rst(rst), .sck(sck),
    .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe), .wp_n(wp_n));

// ==== eep_host_model.sv ====
// host-side serial master model for the eeprom link
`timescale 1ns/1ps
module eep_host_model (
    // serial link toward the device
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe
);
    localparam int HALF = 24;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic open_frame();
        cs_n = 1'b0;
        #30;
    endtask
    // si flips after release so a stale bit never looks valid
    task automatic close_frame();
        #30;
        cs_n = 1'b1;
        si = ~si;
        #150;
    endtask
    // floated output is recorded as unknown
    task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'hxx;
        for (int i = 7; i > 7 - nbits; i--) begin
            si = tx[i];
            #HALF;
            sck = 1'b1;
            rx[i] = so_oe ? so : 1'bx;
            #HALF;
            sck = 1'b0;
        end
    endtask
    // clock and data wiggle while paused; both edges of pause with clock low
    // let the last fall land first: pause at that very instant would freeze it
    task automatic pause();
        #HALF;
        hold_n = 1'b0;
        repeat (3) begin
            si = ~si;
            #HALF;
            sck = 1'b1;
            #HALF;
            sck = 1'b0;
        end
        #HALF;
        hold_n = 1'b1;
        #HALF;
    endtask
endmodule

// ==== spi_serial_eeprom_interface_test.sv ====
// self-checking bench for the serial eeprom front end
`timescale 1ns/1ps
module spi_serial_eeprom_interface_test;
    localparam int PROG = 64;
    localparam int LIMIT = 40000;
    logic core_clk;
    logic rst;
    logic wp_n;
    wire sck, cs_n, si, hold_n, so, so_oe;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [7:0] rx;

    eep_spi_eeprom #(.PROG_CYCLES(PROG)) dut (.core_clk(core_clk), .rst(rst), .sck(sck),
        .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe), .wp_n(wp_n));
    eep_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
        .so_oe(so_oe));

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic set_wp(input logic v);
        @(posedge core_clk);
        #2;
        wp_n = v;
    endtask
    task automatic cmd(input logic [7:0] op);
        host.open_frame();
        host.shift(op, 8, rx);
        host.close_frame();
    endtask
    task automatic expect_status(input logic [7:0] exp);
        host.open_frame();
        host.shift(eep_pkg::OP_STAT_RD, 8, rx);
        host.shift(8'h00, 8, rx);
        host.close_frame();
        check("status byte", rx, exp);
    endtask
    // top three address bits set on purpose: they must be ignored
    task automatic frame_hdr(input logic [7:0] op, input logic [12:0] a);
        host.open_frame();
        host.shift(op, 8, rx);
        host.shift({3'h7, a[12:8]}, 8, rx);
        host.shift(a[7:0], 8, rx);
    endtask
    task automatic write(input logic [12:0] a, input logic [7:0] d0, input logic [7:0] d1,
        input int n);
        cmd(eep_pkg::OP_LATCH_SET);
        frame_hdr(eep_pkg::OP_WRITE, a);
        host.shift(d0, 8, rx);
        if (n > 1) host.shift(d1, 8, rx);
        host.close_frame();
    endtask
    task automatic wr_status(input logic [7:0] v);
        cmd(eep_pkg::OP_LATCH_SET);
        host.open_frame();
        host.shift(eep_pkg::OP_STAT_WR, 8, rx);
        host.shift(v, 8, rx);
        host.close_frame();
    endtask
    task automatic wait_prog();
        repeat (PROG + 8) @(posedge core_clk);
    endtask
    task automatic read2(input logic [12:0] a, input logic [7:0] e0, input logic [7:0] e1);
        frame_hdr(eep_pkg::OP_READ, a);
        host.shift(8'h00, 8, rx);
        check("read byte 0", rx, e0);
        host.shift(8'h00, 8, rx);
        check("read byte 1", rx, e1);
        host.close_frame();
    endtask

    task automatic t_latch();
        expect_status(8'h00);
        cmd(eep_pkg::OP_LATCH_SET);
        expect_status(8'h02);
        cmd(eep_pkg::OP_LATCH_CLR);
        expect_status(8'h00);
        host.open_frame();
        host.shift(eep_pkg::OP_LATCH_SET, 8, rx);
        host.shift(eep_pkg::OP_WRITE, 8, rx);
        host.close_frame();
        expect_status(8'h00);
    endtask
    task automatic t_write();
        write(13'h1fff, 8'ha5, 8'h3c, 2);
        expect_status(8'h03);
        read2(13'h1fff, 8'hxx, 8'hxx);
        wait_prog();
        expect_status(8'h00);
        write(13'h0000, 8'h5a, 8'h00, 1);
        wait_prog();
        read2(13'h1fff, 8'ha5, 8'h5a);
        read2(13'h1fe0, 8'h3c, 8'hxx);
    endtask
    task automatic t_abort();
        cmd(eep_pkg::OP_LATCH_SET);
        frame_hdr(eep_pkg::OP_WRITE, 13'h0000);
        host.shift(8'hff, 8, rx);
        host.shift(8'hff, 3, rx);
        host.close_frame();
        expect_status(8'h02);
        read2(13'h0000, 8'h5a, 8'hxx);
        cmd(8'h07);
        expect_status(8'h02);
        cmd(eep_pkg::OP_LATCH_CLR);
    endtask
    task automatic t_pause();
        host.open_frame();
        host.shift(eep_pkg::OP_READ, 8, rx);
        host.shift(8'hff, 8, rx);
        host.pause();
        host.shift(8'hff, 8, rx);
        host.shift(8'h00, 8, rx);
        check("paused read byte 0", rx, 8'ha5);
        host.pause();
        host.shift(8'h00, 8, rx);
        check("paused read byte 1", rx, 8'h5a);
        host.close_frame();
    endtask
    task automatic t_protect();
        wr_status(8'h04);
        wait_prog();
        expect_status(8'h04);
        write(13'h1800, 8'h11, 8'h00, 1);
        expect_status(8'h06);
        wr_status(8'h84);
        wait_prog();
        expect_status(8'h84);
        set_wp(1'b0);
        wr_status(8'h00);
        expect_status(8'h86);
        set_wp(1'b1);
        wr_status(8'h00);
        set_wp(1'b0);
        wait_prog();
        expect_status(8'h00);
        set_wp(1'b1);
    endtask

    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        repeat (12) @(posedge core_clk);
        #2;
        rst = 1'b0;
        repeat (4) @(posedge core_clk);
        t_latch();
        t_write();
        t_abort();
        t_pause();
        t_protect();
        final_report();
    end
endmodule
